/* verilog/vifc_pkg.sv */
`default_nettype none
package vifc_pkg;
  // source map
  localparam int NSRC   = 22;
  localparam int NEXT   = 4;
  localparam int EXT_LO = 18;
  localparam int PW     = 3;
  localparam int NLVL   = 8;
  localparam int FW     = 4;
  localparam int AW     = 12;
  // register offsets
  localparam logic [AW-1:0] A_IRQ_ACT  = 12'h000;
  localparam logic [AW-1:0] A_IRQ_RAW  = 12'h004;
  localparam logic [AW-1:0] A_IRQ_EN   = 12'h008;
  localparam logic [AW-1:0] A_IRQ_DIS  = 12'h00C;
  localparam logic [AW-1:0] A_SWI      = 12'h010;
  localparam logic [AW-1:0] A_BASE     = 12'h014;
  localparam logic [AW-1:0] A_IRQ_VEC  = 12'h01C;
  localparam logic [AW-1:0] A_PRIO_LO  = 12'h020;
  localparam logic [AW-1:0] A_PRIO_MID = 12'h024;
  localparam logic [AW-1:0] A_PRIO_HI  = 12'h028;
  localparam logic [AW-1:0] A_RSVD     = 12'h02C;
  localparam logic [AW-1:0] A_NEST     = 12'h030;
  localparam logic [AW-1:0] A_TRIG     = 12'h034;
  localparam logic [AW-1:0] A_ECLR     = 12'h038;
  localparam logic [AW-1:0] A_IRQ_TKN  = 12'h03C;
  localparam logic [AW-1:0] A_FIQ_ACT  = 12'h100;
  localparam logic [AW-1:0] A_FIQ_RAW  = 12'h104;
  localparam logic [AW-1:0] A_FIQ_EN   = 12'h108;
  localparam logic [AW-1:0] A_FIQ_DIS  = 12'h10C;
  localparam logic [AW-1:0] A_FIQ_VEC  = 12'h11C;
  localparam logic [AW-1:0] A_FIQ_TKN  = 12'h13C;
  // nesting control bits
  localparam int NEST_IRQ = 0;
  localparam int NEST_FIQ = 1;
  // trigger encodings
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_LVL  = 2'h2;
  // vector slot shift (2-byte slots in 64-byte table)
  localparam int SLOT_SH = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
  } vifc_apb_req_t;

  typedef struct packed {
    logic       hit;
    logic [4:0] src;
    logic [2:0] lvl;
  } vifc_sel_t;

  typedef struct packed {
    logic [NSRC-1:0]    irq_en;
    logic [NSRC-1:0]    fiq_en;
    logic [NSRC-1:0]    swi;
    logic [31:0]        base;
    logic [NSRC*PW-1:0] prio;
    logic [1:0]         nest;
    logic [2*NEXT-1:0]  trig;
    logic [NEXT-1:0]    latch;
    logic [NEXT-1:0]    prev;
    logic [NLVL-1:0]    irq_tkn;
    logic [NLVL-1:0]    fiq_tkn;
    logic               irq;
    logic               fiq;
    logic [31:0]        rdata;
  } vifc_state_t;
endpackage
`default_nettype wire

/* verilog/vifc_top.sv */
// Contract
// - irq raw and enabled-active source registers readable
// - irq enable read/write, disable write-one clears
// - software trigger register asserts sources directly
// - writable vector base for 64-byte handler table
// - irq vector returns base plus active slot
// - 3-bit priority per source, three registers
// - nesting control gates higher-priority nesting
// - external inputs rise, fall or level triggered
// - edge clear write drops latched edge
// - irq taken priority recorded, read/write
// - fiq raw and active source registers
// - fiq enable, disable and vector registers
// - fiq taken priority recorded, read/write
// - registers on two-cycle peripheral bus
// - fast request takes precedence over normal
`timescale 1ns/1ps
`default_nettype none
module vifc_top (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rstn,
  // interrupt sources
  input  wire logic [vifc_pkg::NSRC-1:0] i_src,
  input  wire logic [vifc_pkg::NEXT-1:0] i_ext,
  // peripheral bus
  input  wire vifc_pkg::vifc_apb_req_t i_apb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // core requests
  output logic                         o_irq,
  output logic                         o_fiq
);
  localparam int NSRC = vifc_pkg::NSRC;
  localparam int PW   = vifc_pkg::PW;
  localparam int NLVL = vifc_pkg::NLVL;

  vifc_pkg::vifc_state_t st_r;
  vifc_pkg::vifc_state_t st_nxt;

  function automatic logic [PW-1:0] lvl_of(input logic [NSRC*PW-1:0] p, input int s);
    lvl_of = p[s*PW +: PW];
  endfunction

  // lowest level wins, ties to lowest source index
  function automatic vifc_pkg::vifc_sel_t pick(input logic [NSRC-1:0] act,
                                               input logic [NSRC*PW-1:0] p);
    vifc_pkg::vifc_sel_t r;
    r = '0;
    for (int s = NSRC-1; s >= 0; s--)
    begin
      if (act[s] && (!r.hit || lvl_of(p, s) <= r.lvl))
      begin
        r.hit = 1'b1;
        r.src = 5'(s);
        r.lvl = lvl_of(p, s);
      end
    end
    pick = r;
  endfunction

  // no nesting or nothing taken: any hit; else strictly more urgent level
  function automatic logic allow(input vifc_pkg::vifc_sel_t sl, input logic nest,
                                 input logic [NLVL-1:0] tkn);
    logic ok;
    ok = (tkn == '0) || !nest;
    for (int l = NLVL-1; l >= 0; l--)
    begin
      if (nest && tkn[l])
        ok = (32'(sl.lvl) < l);
    end
    allow = sl.hit && ok;
  endfunction

  function automatic logic [31:0] vec(input logic [31:0] base, input vifc_pkg::vifc_sel_t sl);
    vec = base + 32'({sl.src, {vifc_pkg::SLOT_SH{1'b0}}});
  endfunction

  function automatic logic [31:0] zx(input logic [NSRC-1:0] v);
    zx = 32'(v);
  endfunction

  // priority register image: field of source s at (s mod 8) nibble
  function automatic logic [31:0] prio_word(input logic [NSRC*PW-1:0] p, input int grp);
    logic [31:0] w;
    w = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      if (s / 8 == grp)
        w[(s % 8)*vifc_pkg::FW +: PW] = lvl_of(p, s);
    end
    prio_word = w;
  endfunction

  logic [NSRC-1:0]           raw;
  logic [NSRC-1:0]           irq_act;
  logic [NSRC-1:0]           fiq_act;
  logic [vifc_pkg::NEXT-1:0] ext_eff;
  logic [vifc_pkg::NEXT-1:0] edge_set;
  vifc_pkg::vifc_sel_t       isel;
  vifc_pkg::vifc_sel_t       fsel;
  logic                      setup;
  logic                      wr;
  logic                      rd_acc;
  logic                      mapped;
  logic [31:0]               rmux;

  always_comb
  begin
    for (int e = 0; e < vifc_pkg::NEXT; e++)
    begin
      unique case (st_r.trig[2*e +: 2])
        vifc_pkg::TRIG_RISE: edge_set[e] = i_ext[e] && !st_r.prev[e];
        vifc_pkg::TRIG_FALL: edge_set[e] = !i_ext[e] && st_r.prev[e];
        default:             edge_set[e] = 1'b0;
      endcase
      ext_eff[e] = (st_r.trig[2*e +: 2] == vifc_pkg::TRIG_LVL) ? i_ext[e] : st_r.latch[e];
    end
    raw = i_src | st_r.swi;
    raw[vifc_pkg::EXT_LO +: vifc_pkg::NEXT] = ext_eff | st_r.swi[vifc_pkg::EXT_LO +: vifc_pkg::NEXT];
    irq_act = raw & st_r.irq_en;
    fiq_act = raw & st_r.fiq_en;
    isel = pick(irq_act, st_r.prio);
    fsel = pick(fiq_act, st_r.prio);
  end

  // bus decode
  always_comb
  begin
    setup  = i_apb.psel && !i_apb.penable;
    wr     = i_apb.psel && i_apb.penable && i_apb.pwrite;
    rd_acc = i_apb.psel && i_apb.penable && !i_apb.pwrite;
    mapped = 1'b1;
    rmux   = vifc_pkg::RST_WORD;
    unique case (i_apb.paddr)
      vifc_pkg::A_IRQ_ACT:  rmux = zx(irq_act);
      vifc_pkg::A_IRQ_RAW:  rmux = zx(raw);
      vifc_pkg::A_IRQ_EN:   rmux = zx(st_r.irq_en);
      vifc_pkg::A_BASE:     rmux = st_r.base;
      vifc_pkg::A_IRQ_VEC:  rmux = vec(st_r.base, isel);
      vifc_pkg::A_PRIO_LO:  rmux = prio_word(st_r.prio, 0);
      vifc_pkg::A_PRIO_MID: rmux = prio_word(st_r.prio, 1);
      vifc_pkg::A_PRIO_HI:  rmux = prio_word(st_r.prio, 2);
      vifc_pkg::A_NEST:     rmux = 32'(st_r.nest);
      vifc_pkg::A_TRIG:     rmux = 32'(st_r.trig);
      vifc_pkg::A_IRQ_TKN:  rmux = 32'(st_r.irq_tkn);
      vifc_pkg::A_FIQ_ACT:  rmux = zx(fiq_act);
      vifc_pkg::A_FIQ_RAW:  rmux = zx(raw);
      vifc_pkg::A_FIQ_EN:   rmux = zx(st_r.fiq_en);
      vifc_pkg::A_FIQ_VEC:  rmux = vec(st_r.base, fsel);
      vifc_pkg::A_FIQ_TKN:  rmux = 32'(st_r.fiq_tkn);
      vifc_pkg::A_IRQ_DIS, vifc_pkg::A_FIQ_DIS, vifc_pkg::A_SWI,
      vifc_pkg::A_ECLR, vifc_pkg::A_RSVD: rmux = vifc_pkg::RST_WORD;
      default:              mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.prev  = i_ext;
    st_nxt.latch = st_r.latch | edge_set;
    if (setup)
      st_nxt.rdata = rmux;
    if (wr)
    begin
      unique case (i_apb.paddr)
        vifc_pkg::A_IRQ_EN:  st_nxt.irq_en = i_apb.pwdata[NSRC-1:0];
        vifc_pkg::A_IRQ_DIS: st_nxt.irq_en = st_r.irq_en & ~i_apb.pwdata[NSRC-1:0];
        vifc_pkg::A_FIQ_EN:  st_nxt.fiq_en = i_apb.pwdata[NSRC-1:0];
        vifc_pkg::A_FIQ_DIS: st_nxt.fiq_en = st_r.fiq_en & ~i_apb.pwdata[NSRC-1:0];
        vifc_pkg::A_SWI:     st_nxt.swi = i_apb.pwdata[NSRC-1:0];
        vifc_pkg::A_BASE:    st_nxt.base = i_apb.pwdata;
        vifc_pkg::A_PRIO_LO, vifc_pkg::A_PRIO_MID, vifc_pkg::A_PRIO_HI:
        begin
          for (int s = 0; s < NSRC; s++)
          begin
            if (32'(s / 8) == 32'(i_apb.paddr[3:2]))
              st_nxt.prio[s*PW +: PW] = i_apb.pwdata[(s % 8)*vifc_pkg::FW +: PW];
          end
        end
        vifc_pkg::A_NEST:    st_nxt.nest = i_apb.pwdata[1:0];
        vifc_pkg::A_TRIG:    st_nxt.trig = i_apb.pwdata[2*vifc_pkg::NEXT-1:0];
        vifc_pkg::A_ECLR:    st_nxt.latch = (st_r.latch & ~i_apb.pwdata[vifc_pkg::NEXT-1:0])
                                            | edge_set;
        vifc_pkg::A_IRQ_TKN: st_nxt.irq_tkn = i_apb.pwdata[NLVL-1:0];
        vifc_pkg::A_FIQ_TKN: st_nxt.fiq_tkn = i_apb.pwdata[NLVL-1:0];
        default:             st_nxt.swi = st_r.swi;
      endcase
    end
    // vector read marks entry: record level, set wins over software write
    if (rd_acc && i_apb.paddr == vifc_pkg::A_IRQ_VEC && isel.hit)
      st_nxt.irq_tkn[isel.lvl] = 1'b1;
    if (rd_acc && i_apb.paddr == vifc_pkg::A_FIQ_VEC && fsel.hit)
      st_nxt.fiq_tkn[fsel.lvl] = 1'b1;
    st_nxt.fiq = allow(fsel, st_r.nest[vifc_pkg::NEST_FIQ], st_r.fiq_tkn);
    st_nxt.irq = allow(isel, st_r.nest[vifc_pkg::NEST_IRQ], st_r.irq_tkn) && !st_nxt.fiq;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_prdata  = st_r.rdata;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_apb.psel && i_apb.penable && !mapped;
  assign o_irq     = st_r.irq;
  assign o_fiq     = st_r.fiq;
endmodule // vifc_top
`default_nettype wire

/* verification/vifc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module vifc_chk (
  // watched ports
  input wire logic                      i_sys_clk,
  input wire logic                      i_rstn,
  input wire logic [vifc_pkg::NSRC-1:0] i_src,
  input wire logic [vifc_pkg::NEXT-1:0] i_ext,
  input wire vifc_pkg::vifc_apb_req_t   i_apb,
  input wire logic [31:0]               o_prdata,
  input wire logic                      o_pready,
  input wire logic                      o_pslverr,
  input wire logic                      o_irq,
  input wire logic                      o_fiq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic acc;
  assign acc = i_apb.psel && i_apb.penable;
  ready_high_a: assert property (o_pready)
    else $error("bus ready dropped");
  unmapped_err_a: assert property (acc && i_apb.paddr == 12'h018 |-> o_pslverr)
    else $error("no error on unmapped offset");
  mapped_ok_a: assert property (acc && i_apb.paddr == 12'h008 |-> !o_pslverr)
    else $error("error on enable register");
  fiq_first_a: assert property (o_fiq |-> !o_irq)
    else $error("normal request beside fast one");
  wo_zero_a: assert property (acc && !i_apb.pwrite && i_apb.paddr == 12'h010 |-> o_prdata == 32'h0)
    else $error("write-only register reads nonzero");
  src_width_a: assert property (acc && !i_apb.pwrite && i_apb.paddr inside {12'h000, 12'h004, 12'h008,
    12'h100, 12'h104, 12'h108} |-> o_prdata[31:22] == 10'h0)
    else $error("source bits above 21 set");
  irq_dis_a: assert property (acc && i_apb.pwrite && i_apb.paddr == 12'h00C &&
    i_apb.pwdata[21:0] == 22'h3FFFFF |-> ##[1:3] !o_irq)
    else $error("normal request survives disable");
  fiq_dis_a: assert property (acc && i_apb.pwrite && i_apb.paddr == 12'h10C &&
    i_apb.pwdata[21:0] == 22'h3FFFFF |-> ##[1:3] !o_fiq)
    else $error("fast request survives disable");
endmodule // vifc_chk
bind vifc_top vifc_chk u_vifc_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_src(i_src), .i_ext(i_ext),
  .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .o_fiq(o_fiq));
`default_nettype wire

/* verification/vifc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vifc_core_model (
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  // requests
  input  wire logic  i_irq,
  input  wire logic  i_fiq,
  // cycles spent in normal handling
  output logic [7:0] o_irq_cnt
);
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      o_irq_cnt <= 8'h00;
    else if (i_irq && !i_fiq)
      o_irq_cnt <= o_irq_cnt + 8'h01;
endmodule // vifc_core_model
`default_nettype wire

/* verification/vifc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                    clk;
  logic                    rstn;
  logic [21:0]             src;
  logic [3:0]              ext;
  vifc_pkg::vifc_apb_req_t apb;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    fiq;
  logic                    err;
  logic [7:0]              n_irq;
  int                      n_fail;
  int                      samples_checked;
  int                      seed;
  logic [31:0]             d;
  logic [31:0]             e;
  logic [11:0]             rz [15] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h02C,
                                       12'h030, 12'h034, 12'h03C, 12'h100, 12'h108, 12'h11C, 12'h13C};
  vifc_top u_vifc_top (.i_sys_clk(clk), .i_rstn(rstn), .i_src(src), .i_ext(ext), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_fiq(fiq));
  vifc_core_model u_vifc_core_model (.i_clk(clk), .i_rstn(rstn), .i_irq(irq), .i_fiq(fiq), .o_irq_cnt(n_irq));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] pf(input int s, input logic [2:0] p);
    return {29'h0, p} << ((s % 8) * 4);
  endfunction
  function automatic logic [31:0] vx(input logic [31:0] b, input int s);
    return b + 32'(s * 2);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(negedge clk);
    apb = '{1'b1, 1'b0, 1'b1, a, v};
    @(negedge clk);
    apb.penable = 1'b1;
    @(negedge clk);
    apb = '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    apb = '{1'b1, 1'b0, 1'b0, a, 32'h0};
    @(negedge clk);
    apb.penable = 1'b1;
    #1 err = pslverr;
    chk(prdata, exp);
    @(negedge clk);
    apb = '0;
  endtask
  task automatic idle;
    repeat (3) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000 n_fail++;
    finish_test();
  end
  initial
  begin
    seed = 32'h790d;
    rstn = 1'b0;
    src = '0;
    ext = '0;
    apb = '0;
    repeat (2) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    foreach (rz[i]) rd(rz[i], 32'h0);
    rd(12'h018, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test done: reset and map");
    repeat (8)
    begin
      d = $random(seed);
      e = $random(seed);
      wr(12'h008, d);
      wr(12'h00C, e);
      rd(12'h008, {10'h0, d[21:0] & ~e[21:0]});
      src = {4'h0, e[31:14]};
      idle();
      rd(12'h004, {14'h0, e[31:14]});
      rd(12'h000, {14'h0, e[31:14] & d[17:0] & ~e[17:0]});
      wr(12'h00C, 32'hFFFF_FFFF);
    end
    src = '0;
    wr(12'h010, 32'h20);
    wr(12'h008, 32'h20);
    rd(12'h004, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(12'h010, 32'h0);
    $display("test done: enable and software");
    d = $random(seed) & 32'hFFFF_FFC0;
    wr(12'h014, d);
    wr(12'h020, pf(3, 5));
    wr(12'h024, pf(12, 2));
    rd(12'h024, pf(12, 2));
    src = 22'h1008;
    wr(12'h008, 32'h1008);
    idle();
    rd(12'h01C, vx(d, 12));
    rd(12'h03C, 32'h4);
    wr(12'h030, 32'h1);
    idle();
    chk({31'h0, irq}, 32'h0);
    wr(12'h03C, 32'h0);
    idle();
    chk({31'h0, irq}, 32'h1);
    wr(12'h108, 32'h8);
    idle();
    chk({30'h0, irq, fiq}, 32'h1);
    rd(12'h100, 32'h8);
    rd(12'h104, 32'h1008);
    rd(12'h11C, vx(d, 3));
    rd(12'h13C, 32'h20);
    wr(12'h10C, 32'hFFFF_FFFF);
    idle();
    chk({30'h0, irq, fiq}, 32'h2);
    wr(12'h00C, 32'hFFFF_FFFF);
    src = '0;
    $display("test done: vectors and nesting");
    for (int m = 0; m < 3; m++)
    begin
      wr(12'h034, 32'(m));
      ext[0] = 1'b1;
      idle();
      rd(12'h004, (m != 1) ? 32'h4_0000 : 32'h0);
      ext[0] = 1'b0;
      idle();
      rd(12'h004, (m != 2) ? 32'h4_0000 : 32'h0);
      wr(12'h038, 32'h1);
      rd(12'h004, 32'h0);
    end
    chk({31'h0, n_irq != 8'h00}, 32'h1);
    $display("test done: external triggers");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
